// ### common/qpfe_pkg.sv
/*
 * Constants for the four-phase fetch/execute pipeline controller.
 * Assumes a single clock domain; no software-visible registers.
 */
package qpfe_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int PC_WIDTH    = 13;
    localparam int INSTR_WIDTH = 14;
    localparam int DATA_WIDTH  = 8;
    localparam int DADDR_WIDTH = 9;

    // ------------------------------------------------------------
    // Phases and reset values
    // ------------------------------------------------------------
    localparam int PHASE_COUNT = 4;

    typedef enum logic [1:0] {
        PHASE_ONE   = 2'h0,
        PHASE_TWO   = 2'h1,
        PHASE_THREE = 2'h3,
        PHASE_FOUR  = 2'h2
    } phase_e;

    localparam logic [PC_WIDTH-1:0]    PC_RESET    = 13'h0000;
    localparam logic [INSTR_WIDTH-1:0] INSTR_RESET = 14'h0000;

endpackage

// ### logic/quad_phase_fetch_execute.sv
/*
 * Four-phase timing and two-stage fetch/execute pipeline controller.
 * Assumes program memory answers progData combinationally from progAddr,
 * and that an execution unit outside supplies the decoded results
 * (branch request, target, write enable, write address and data).
 */
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Input clock divided by four into four non-overlapping phases per cycle.
// - Program counter increments once per instruction cycle, in phase one.
// - Fetched word latched into instruction register at closing phase four.
// - Latched instruction decoded and executed across phases two to four.
// - Operand read in phase two; result written in phase four.
// - Fetch of next overlaps execute of current; one instruction per cycle.
// - Branch takes two cycles; prefetched word discarded while target fetched.
module quad_phase_fetch_execute #(
    parameter int PC_W    = qpfe_pkg::PC_WIDTH,
    parameter int INSTR_W = qpfe_pkg::INSTR_WIDTH,
    parameter int DATA_W  = qpfe_pkg::DATA_WIDTH,
    parameter int DADDR_W = qpfe_pkg::DADDR_WIDTH
) (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               arst_n,
    // Phase outputs
    output var  logic               phaseOne,
    output var  logic               phaseTwo,
    output var  logic               phaseThree,
    output var  logic               phaseFour,
    // Program memory
    output var  logic [PC_W-1:0]    progAddr,
    input  wire logic [INSTR_W-1:0] progData,
    // Execution unit
    output var  logic [INSTR_W-1:0] instrReg,
    output var  logic               execValid,
    input  wire logic               branchReq,
    input  wire logic [PC_W-1:0]    branchTarget,
    input  wire logic               resultWrite,
    input  wire logic [DADDR_W-1:0] resultAddr,
    input  wire logic [DATA_W-1:0]  resultData,
    input  wire logic [DADDR_W-1:0] operandAddr,
    // Data memory
    output var  logic               dataRead,
    output var  logic [DADDR_W-1:0] dataReadAddr,
    output var  logic               dataWrite,
    output var  logic [DADDR_W-1:0] dataWriteAddr,
    output var  logic [DATA_W-1:0]  dataWriteData
);

    if (PC_W < 2 || INSTR_W < 1 || DATA_W < 1 || DADDR_W < 1) begin : g_bad_width
        $error("quad_phase_fetch_execute: widths out of range");
    end

    // ------------------------------------------------------------
    // Phase generator
    // ------------------------------------------------------------
    qpfe_pkg::phase_e phase;
    qpfe_pkg::phase_e next_phase;

    function automatic qpfe_pkg::phase_e advance(input qpfe_pkg::phase_e p);
        case (p)
            qpfe_pkg::PHASE_ONE:   advance = qpfe_pkg::PHASE_TWO;
            qpfe_pkg::PHASE_TWO:   advance = qpfe_pkg::PHASE_THREE;
            qpfe_pkg::PHASE_THREE: advance = qpfe_pkg::PHASE_FOUR;
            default:               advance = qpfe_pkg::PHASE_ONE;
        endcase
    endfunction

    assign next_phase = advance(phase);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= qpfe_pkg::PHASE_FOUR;
        end else begin
            phase <= next_phase;
        end
    end

    // Phase outputs are registered one-hot copies of next_phase
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            phaseOne   <= 1'b0;
            phaseTwo   <= 1'b0;
            phaseThree <= 1'b0;
            phaseFour  <= 1'b0;
        end else begin
            phaseOne   <= (next_phase == qpfe_pkg::PHASE_ONE);
            phaseTwo   <= (next_phase == qpfe_pkg::PHASE_TWO);
            phaseThree <= (next_phase == qpfe_pkg::PHASE_THREE);
            phaseFour  <= (next_phase == qpfe_pkg::PHASE_FOUR);
        end
    end

    // ------------------------------------------------------------
    // Decode of the current phase
    // ------------------------------------------------------------
    wire logic inOne;
    wire logic inTwo;
    wire logic inFour;
    wire logic takeBranch;

    assign inOne  = (phase == qpfe_pkg::PHASE_ONE);
    assign inTwo  = (phase == qpfe_pkg::PHASE_TWO);
    assign inFour = (phase == qpfe_pkg::PHASE_FOUR);
    // Branch acts at the end of the executing cycle, only from a live slot
    assign takeBranch = inFour && execValid && branchReq;

    // ------------------------------------------------------------
    // Program counter and fetch
    // ------------------------------------------------------------
    logic [PC_W-1:0] pc;
    logic            started;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pc       <= qpfe_pkg::PC_RESET;
            progAddr <= qpfe_pkg::PC_RESET;
        end else if (takeBranch) begin
            pc <= branchTarget;
        end else if (inOne) begin
            pc       <= pc + {{(PC_W-1){1'b0}}, 1'b1};
            progAddr <= pc;
        end
    end

    // Marks that the first fetch has begun; nothing is latched before it
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            started <= 1'b0;
        end else if (inOne) begin
            started <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Instruction register and flush
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            instrReg  <= qpfe_pkg::INSTR_RESET;
            execValid <= 1'b0;
        end else if (inFour && started) begin
            instrReg  <= progData;
            execValid <= !takeBranch;
        end
    end

    // ------------------------------------------------------------
    // Data memory strobes
    // ------------------------------------------------------------
    wire logic doRead;
    wire logic doWrite;

    assign doRead  = (next_phase == qpfe_pkg::PHASE_TWO) && execValid;
    assign doWrite = (next_phase == qpfe_pkg::PHASE_FOUR) && execValid
                     && resultWrite;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            dataRead      <= 1'b0;
            dataReadAddr  <= '0;
            dataWrite     <= 1'b0;
            dataWriteAddr <= '0;
            dataWriteData <= '0;
        end else begin
            dataRead      <= doRead;
            dataReadAddr  <= doRead ? operandAddr : dataReadAddr;
            dataWrite     <= doWrite;
            dataWriteAddr <= doWrite ? resultAddr : dataWriteAddr;
            dataWriteData <= doWrite ? resultData : dataWriteData;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_cycle;
        phaseOne ##1 phaseTwo ##1 phaseThree ##1 phaseFour;
    endsequence

    property p_phase_order;
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(phaseOne) |-> s_cycle ##1 phaseOne;
    endproperty
    a_phase_order: assert property (p_phase_order) else $error("phase order broken");

    property p_onehot;
        @(posedge sys_clk) disable iff (!arst_n)
        $onehot({phaseOne, phaseTwo, phaseThree, phaseFour}) || !started;
    endproperty
    a_onehot: assert property (p_onehot) else $error("phases overlap");

    property p_pc_step;
        @(posedge sys_clk) disable iff (!arst_n)
        (inOne && !takeBranch) |=> pc == $past(pc) + 1'b1;
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("pc did not step");

    property p_pc_hold;
        @(posedge sys_clk) disable iff (!arst_n)
        (!inOne && !takeBranch) |=> $stable(pc);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("pc moved outside phase one");

    property p_ir_load;
        @(posedge sys_clk) disable iff (!arst_n)
        (inFour && started) |=> instrReg == $past(progData);
    endproperty
    a_ir_load: assert property (p_ir_load) else $error("instruction not latched");

    property p_read_phase;
        @(posedge sys_clk) disable iff (!arst_n)
        dataRead |-> phaseTwo && execValid;
    endproperty
    a_read_phase: assert property (p_read_phase) else $error("read outside phase two");

    property p_write_phase;
        @(posedge sys_clk) disable iff (!arst_n)
        dataWrite |-> phaseFour && execValid;
    endproperty
    a_write_phase: assert property (p_write_phase) else $error("write outside phase four");

    property p_flush;
        @(posedge sys_clk) disable iff (!arst_n)
        takeBranch |=> !execValid ##1 (!dataRead && !dataWrite) [*3];
    endproperty
    a_flush: assert property (p_flush) else $error("flushed slot had effects");

    property p_nop_pc;
        @(posedge sys_clk) disable iff (!arst_n)
        (inFour && !execValid) |=> ##1 pc == $past(pc, 2) + 1'b1;
    endproperty
    a_nop_pc: assert property (p_nop_pc) else $error("flushed slot moved pc");

endmodule

`default_nettype wire

// ### verif/qpfe_mem_model.sv
/* Program and data memory standing beside the pipeline controller.
   Assumes one clock; a program word is its address with bit 13 set. */
`timescale 1ns/1ps
`default_nettype none
module qpfe_mem_model (
    // Clock
    input  wire logic        sys_clk,
    // Program side
    input  wire logic [12:0] progAddr,
    output var  logic [13:0] progData,
    // Data side
    input  wire logic        dataWrite,
    input  wire logic [8:0]  dataWriteAddr,
    input  wire logic [7:0]  dataWriteData
);
    logic [7:0] mem [512];

    assign progData = {1'b1, progAddr};

    always_ff @(posedge sys_clk) begin
        if (dataWrite) begin
            mem[dataWriteAddr] <= dataWriteData;
        end
    end
endmodule
`default_nettype wire

// ### verif/quad_phase_fetch_execute_test.sv
/* Self-checking bench for the four-phase fetch/execute controller.
   Assumes the memory model above; inputs change on falling edges. */
`timescale 1ns/1ps
`default_nettype none
module quad_phase_fetch_execute_test;
    // ----
    // Signals
    // ----
    logic        sys_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        phaseOne, phaseTwo, phaseThree, phaseFour, execValid, dataRead, dataWrite;
    logic [12:0] progAddr, addr, lastAddr;
    logic [12:0] branchTarget = 13'h0000;
    logic [13:0] progData, instrReg, word;
    logic        branchReq = 1'b0;
    logic        resultWrite = 1'b0;
    logic [8:0]  resultAddr = 9'h000;
    logic [8:0]  operandAddr = 9'h000;
    logic [7:0]  resultData = 8'h00;
    logic [8:0]  dataReadAddr, dataWriteAddr;
    logic [7:0]  dataWriteData;
    int          badCount = 0;
    int          checkCount = 0;

    always #5 sys_clk = ~sys_clk;

    quad_phase_fetch_execute u_quad_phase_fetch_execute (
        .sys_clk(sys_clk), .arst_n(arst_n),
        .phaseOne(phaseOne), .phaseTwo(phaseTwo), .phaseThree(phaseThree),
        .phaseFour(phaseFour), .progAddr(progAddr), .progData(progData),
        .instrReg(instrReg), .execValid(execValid), .branchReq(branchReq),
        .branchTarget(branchTarget), .resultWrite(resultWrite), .resultAddr(resultAddr),
        .resultData(resultData), .operandAddr(operandAddr), .dataRead(dataRead),
        .dataReadAddr(dataReadAddr), .dataWrite(dataWrite), .dataWriteAddr(dataWriteAddr),
        .dataWriteData(dataWriteData));
    qpfe_mem_model u_qpfe_mem_model (.sys_clk(sys_clk), .progAddr(progAddr),
        .progData(progData), .dataWrite(dataWrite), .dataWriteAddr(dataWriteAddr),
        .dataWriteData(dataWriteData));

    // ----
    // Helpers
    // ----
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            badCount++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stopTest();
        $display("checks %0d mismatches %0d", checkCount, badCount);
        if (badCount == 0 && checkCount > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic syncOne();
        for (int i = 0; i < 8 && phaseOne !== 1'b1; i++) begin
            @(negedge sys_clk);
        end
        if (phaseOne !== 1'b1) begin
            badCount++;
            stopTest();
        end
    endtask

    // One instruction cycle, entered at the falling edge inside phase one
    task automatic instCycle(input logic live);
        for (int p = 0; p < 4; p++) begin
            check("phases", {phaseOne, phaseTwo, phaseThree, phaseFour}, 4'h8 >> p);
            check("execValid", execValid, live);
            check("dataRead", dataRead, live && p == 1);
            check("dataWrite", dataWrite, live && resultWrite && p == 3);
            if (p == 1) begin
                addr = progAddr;
                word = instrReg;
                if (live) check("readAddr", dataReadAddr, operandAddr);
            end
            if (p == 3 && live && resultWrite) begin
                check("writeAddr", dataWriteAddr, resultAddr);
                check("writeData", dataWriteData, resultData);
            end
            @(negedge sys_clk);
        end
    endtask

    task automatic liveStep();
        instCycle(1'b1);
        check("instrReg", word, {1'b1, lastAddr});
        check("pcStep", addr, 13'(lastAddr + 13'h0001));
        lastAddr = addr;
    endtask

    // ----
    // Scenarios
    // ----
    task automatic testFetch();
        syncOne();
        instCycle(1'b0);
        check("firstAddr", addr, 13'h0000);
        instCycle(1'b1);
        check("firstWord", word, 14'h2000);
        check("secondAddr", addr, 13'h0001);
        lastAddr = addr;
        repeat (3) liveStep();
    endtask

    task automatic testData();
        for (int k = 0; k < 2; k++) begin
            operandAddr = k ? 9'h1ff : 9'h055;
            resultWrite = k[0];
            resultAddr = k ? 9'h1ff : 9'h020;
            resultData = k ? 8'ha5 : 8'h3c;
            liveStep();
        end
        check("stored", u_qpfe_mem_model.mem[9'h1ff], 8'ha5);
    endtask

    task automatic testBranch();
        branchReq = 1'b1;
        branchTarget = 13'h1ffe;
        liveStep();
        branchTarget = 13'h0100;
        instCycle(1'b0);
        check("target", addr, 13'h1ffe);
        branchReq = 1'b0;
        instCycle(1'b1);
        check("targetWord", word, 14'h3ffe);
        check("noSecondJump", addr, 13'h1fff);
        lastAddr = addr;
        liveStep();
    endtask

    task automatic testReset();
        liveStep();
        arst_n = 1'b0;
        @(negedge sys_clk);
        check("resetAddr", progAddr, 13'h0000);
        check("resetValid", execValid, 1'b0);
        check("resetIr", instrReg, 14'h0000);
        check("resetPhases", {phaseOne, phaseTwo, phaseThree, phaseFour}, 4'h0);
        arst_n = 1'b1;
        testFetch();
    endtask

    initial begin
        repeat (2) @(negedge sys_clk);
        arst_n = 1'b1;
        testFetch();
        testData();
        testBranch();
        testReset();
        stopTest();
    end
endmodule
`default_nettype wire
